// ### position_time_capture_unit.v
// Contract
// [RULE1] two identical, independent capture channels with own settings
// [RULE2] fast unfiltered input latches within 3 us of its change
// [RULE3] channel can be re-armed within 62.6 us of a capture
// [RULE4] source 0..6 selects digital inputs one to seven
// [RULE5] source 7..9 selects serial-line inputs one to three
// [RULE6] source 10 selects the encoder index pulse
// [RULE7] content 0 latches motor position
// [RULE8] content 1 latches internal nanosecond time
// [RULE9] content 2 latches distributed clock time
// [RULE10] content 3 latches position on index and re-arms itself
// [RULE11] must be armed to trigger; unarmed edges ignored; value readable
// [RULE12] edge 1 triggers on rising edge
// [RULE13] edge 2 triggers on falling edge
// [RULE14] edge 3 triggers on either edge
// [RULE15] policy 0 triggers on first capture edge
// [RULE16] policy 1 needs a precondition edge seen before
// [RULE17] policy 2 needs precondition level high at capture edge
// [RULE18] policy 3 needs precondition level low at capture edge
// [RULE19] precondition edge uses same encoding as capture edge
// [RULE20] precondition source uses same numbering as capture source
// [RULE21] modes 0..2 disarm on capture and hold value
// [RULE22] sources synchronised; per-channel done flag for polling
`timescale 1ns/1ps
`default_nettype none
`include "capture_map.vh"
module position_time_capture_unit
#(
   parameter VALUE_WIDTH = 32,
   parameter CHANNELS = 2
)
(
   input wire clock,
   input wire arst_n,
   input wire [6:0] digital_in,
   input wire [2:0] serial_in,
   input wire encoder_index,
   input wire [VALUE_WIDTH-1:0] motor_position,
   input wire [VALUE_WIDTH-1:0] dc_time,
   input wire [CHANNELS*4-1:0] capture_source_select,
   input wire [CHANNELS*2-1:0] capture_content_select,
   input wire [CHANNELS*2-1:0] capture_edge_select,
   input wire [CHANNELS*2-1:0] precondition_policy,
   input wire [CHANNELS*2-1:0] precondition_edge_select,
   input wire [CHANNELS*4-1:0] precondition_source_select,
   input wire [CHANNELS-1:0] capture_arm,
   input wire [CHANNELS-1:0] capture_done_clear,
   output reg [CHANNELS*VALUE_WIDTH-1:0] captured_value,
   output reg [CHANNELS-1:0] capture_armed,
   output reg [CHANNELS-1:0] capture_done,
   output reg [VALUE_WIDTH-1:0] ns_time
);
   // latency budgets in cycles; the design meets them with large margin
   localparam LATCH_CYCLES = `LATCH_LIMIT_NS / `CLOCK_PERIOD_NS;
   localparam REARM_CYCLES = `REARM_LIMIT_NS / `CLOCK_PERIOD_NS;
   localparam [VALUE_WIDTH-1:0] NS_STEP = `CLOCK_PERIOD_NS;

   wire [10:0] raw_sources;
   wire [10:0] sources;

   // [RULE4] [RULE5] [RULE6] bit order matches source numbering
   assign raw_sources = {encoder_index, serial_in, digital_in};

   // [RULE22] all pins synchronised once, shared by both channels
   input_sync #(.WIDTH(11)) u_sync
   (
      .clock(clock),
      .arst_n(arst_n),
      .pins(raw_sources),
      .pins_sync(sources)
   );

   // [RULE8] free-running nanosecond clock of the drive
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         ns_time <= {VALUE_WIDTH{1'b0}};
      else
         ns_time <= ns_time + NS_STEP;
   end

   genvar ch;
   // [RULE1] one identical channel per loop pass
   generate
      for (ch = 0; ch < CHANNELS; ch = ch + 1)
      begin : chan
         wire [1:0] mode;
         wire [3:0] cap_src;
         wire cap_level;
         wire cap_hit;
         wire pre_level;
         wire pre_hit;
         wire [1:0] policy;
         reg pre_seen_ff;
         reg qualified;
         reg [VALUE_WIDTH-1:0] pick;
         wire fire;

         assign mode = capture_content_select[ch*2 +: 2];
         assign policy = precondition_policy[ch*2 +: 2];
         // [RULE10] index mode forces the encoder index as source
         assign cap_src = (mode == `CONT_INDEX_AUTO) ? `SRC_INDEX :
                          capture_source_select[ch*4 +: 4];

         // [RULE12] [RULE13] [RULE14] capture edge detector
         edge_detect u_cap
         (
            .clock(clock),
            .arst_n(arst_n),
            .sources(sources),
            .source_select(cap_src),
            .edge_select(capture_edge_select[ch*2 +: 2]),
            .level(cap_level),
            .hit(cap_hit)
         );

         // [RULE19] [RULE20] precondition uses the same detector
         edge_detect u_pre
         (
            .clock(clock),
            .arst_n(arst_n),
            .sources(sources),
            .source_select(precondition_source_select[ch*4 +: 4]),
            .edge_select(precondition_edge_select[ch*2 +: 2]),
            .level(pre_level),
            .hit(pre_hit)
         );

         // qualify the capture edge by the precondition policy
         always @*
         begin
            case (policy)
               // [RULE15] no precondition
               `POL_NONE: qualified = 1'b1;
               // [RULE16] earlier precondition edge
               `POL_AFTER: qualified = pre_seen_ff;
               // [RULE17] precondition high
               `POL_HIGH: qualified = pre_level;
               // [RULE18] precondition low
               `POL_LOW: qualified = !pre_level;
               default: qualified = 1'b0;
            endcase
         end

         // [RULE11] unarmed channels ignore edges
         assign fire = capture_armed[ch] && cap_hit && qualified;

         // [RULE7] [RULE8] [RULE9] quantity chosen by content select
         always @*
         begin
            case (mode)
               `CONT_POSITION: pick = motor_position;
               `CONT_NS_TIME: pick = ns_time;
               `CONT_DC_TIME: pick = dc_time;
               `CONT_INDEX_AUTO: pick = motor_position;
               default: pick = motor_position;
            endcase
         end

         // precondition memory; restarts with each arm so stale edges
         // from an earlier cycle cannot qualify a new capture
         always @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               pre_seen_ff <= 1'b0;
            else if (capture_arm[ch] || fire)
               pre_seen_ff <= 1'b0;
            else if (capture_armed[ch] && pre_hit)
               pre_seen_ff <= 1'b1;
         end

         // [RULE2] latch lands one cycle after the synchronised edge
         always @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               captured_value[ch*VALUE_WIDTH +: VALUE_WIDTH] <=
                  {VALUE_WIDTH{1'b0}};
            else if (fire)
               captured_value[ch*VALUE_WIDTH +: VALUE_WIDTH] <= pick;
         end

         // [RULE21] [RULE10] [RULE3] arm state; re-arm is one cycle
         always @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               capture_armed[ch] <= 1'b0;
            else if (fire && mode != `CONT_INDEX_AUTO)
               capture_armed[ch] <= 1'b0;
            else if (capture_arm[ch])
               capture_armed[ch] <= 1'b1;
         end

         // [RULE22] done flag, a new capture beats a clear
         always @(posedge clock or negedge arst_n)
         begin
            if (!arst_n)
               capture_done[ch] <= 1'b0;
            else if (fire)
               capture_done[ch] <= 1'b1;
            else if (capture_done_clear[ch] || capture_arm[ch])
               capture_done[ch] <= 1'b0;
         end
      end
   endgenerate
endmodule // position_time_capture_unit
`default_nettype wire

// ### capture_map.vh
`ifndef CAPTURE_MAP_VH
`define CAPTURE_MAP_VH
// source select codes
`define SRC_DIN_LAST 4'h6
`define SRC_SER_FIRST 4'h7
`define SRC_SER_LAST 4'h9
`define SRC_INDEX 4'ha
// content select codes
`define CONT_POSITION 2'h0
`define CONT_NS_TIME 2'h1
`define CONT_DC_TIME 2'h2
`define CONT_INDEX_AUTO 2'h3
// edge select codes
`define EDGE_RISE 2'h1
`define EDGE_FALL 2'h2
`define EDGE_BOTH 2'h3
// precondition policy codes
`define POL_NONE 2'h0
`define POL_AFTER 2'h1
`define POL_HIGH 2'h2
`define POL_LOW 2'h3
// timing limits in nanoseconds
`define LATCH_LIMIT_NS 3000
`define REARM_LIMIT_NS 62600
`define CLOCK_PERIOD_NS 40
`endif

// ### input_sync.v
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for a bank of pin inputs
module input_sync
#(
   parameter WIDTH = 11
)
(
   input wire clock,
   input wire arst_n,
   input wire [WIDTH-1:0] pins,
   output wire [WIDTH-1:0] pins_sync
);
   reg [WIDTH-1:0] meta_ff;
   reg [WIDTH-1:0] sync_ff;
   // first stage is read only by the second stage
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_ff <= {WIDTH{1'b0}};
         sync_ff <= {WIDTH{1'b0}};
      end
      else
      begin
         meta_ff <= pins;
         sync_ff <= meta_ff;
      end
   end
   assign pins_sync = sync_ff;
endmodule // input_sync
`default_nettype wire

// ### edge_detect.v
`timescale 1ns/1ps
`default_nettype none
`include "capture_map.vh"
// picks one synchronised source and flags the selected edge type
module edge_detect
(
   input wire clock,
   input wire arst_n,
   input wire [10:0] sources,
   input wire [3:0] source_select,
   input wire [1:0] edge_select,
   output wire level,
   output wire hit
);
   reg prev_ff;
   reg sel;
   // codes above the index pick nothing and never fire
   always @*
   begin
      if (source_select <= `SRC_INDEX)
         sel = sources[source_select];
      else
         sel = 1'b0;
   end
   // previous sample for edge comparison
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         prev_ff <= 1'b0;
      else
         prev_ff <= sel;
   end
   assign level = sel;
   assign hit = ((edge_select == `EDGE_RISE) && sel && !prev_ff) ||
                ((edge_select == `EDGE_FALL) && !sel && prev_ff) ||
                ((edge_select == `EDGE_BOTH) && (sel != prev_ff));
endmodule // edge_detect
`default_nettype wire

// ### field_model.sv
`timescale 1ns/1ps
`default_nettype none
// field side: sensor pins, encoder index and a moving axis
module field_model
(
   input wire clock,
   input wire [10:0] pin_req,
   input wire [15:0] noise,
   output wire [6:0] digital_in,
   output wire [2:0] serial_in,
   output wire encoder_index,
   output logic [31:0] motor_position,
   output logic [31:0] dc_time
);
   // sensors drive plain levels, so pins simply follow the request
   assign {encoder_index, serial_in, digital_in} = pin_req;
   initial
   begin
      motor_position = 32'h0;
      dc_time = 32'h0;
   end
   // random steps so a late or early latch shows a different value
   always @(negedge clock)
   begin
      motor_position <= motor_position + {24'h0, noise[7:0]};
      dc_time <= dc_time + {16'h0, noise} + 32'h1;
   end
endmodule // field_model
`default_nettype wire

// ### capture_checker_properties.sv
`timescale 1ns/1ps
`default_nettype none
// watches channel 0 at the unit's pins
module capture_checker
#(
   parameter VALUE_WIDTH = 32,
   parameter CHANNELS = 2
)
(
   input wire clock,
   input wire arst_n,
   input wire [CHANNELS*2-1:0] capture_content_select,
   input wire [CHANNELS-1:0] capture_arm,
   input wire [CHANNELS-1:0] capture_done_clear,
   input wire [CHANNELS*VALUE_WIDTH-1:0] captured_value,
   input wire [CHANNELS-1:0] capture_armed,
   input wire [CHANNELS-1:0] capture_done,
   input wire [VALUE_WIDTH-1:0] ns_time
);
   default clocking @(posedge clock); endclocking
   default disable iff (!arst_n);
   wire [1:0] md = capture_content_select[1:0];
   wire [31:0] cv = captured_value[31:0];
   sequence s_fire; $rose(capture_done[0]); endsequence
   // two idle samples cover either depth of the fire pipeline
   sequence s_idle; (!capture_armed[0]) [*2]; endsequence
   property p_arm; !capture_armed[0] && capture_arm[0] |=> capture_armed[0];
   endproperty
   a_arm: assert property (p_arm) else $error("arm ignored");
   property p_idle; s_idle |=> !$rose(capture_done[0]); endproperty
   a_idle: assert property (p_idle) else $error("fired unarmed");
   property p_hold; $changed(cv) |-> $rose(capture_done[0]) || md == 2'h3;
   endproperty
   a_hold: assert property (p_hold) else $error("value moved");
   property p_disarm; $rose(capture_done[0]) && md != 2'h3 |-> !capture_armed[0];
   endproperty
   a_disarm: assert property (p_disarm) else $error("still armed");
   property p_tick; $past(arst_n) |-> ns_time == $past(ns_time) + 32'd40;
   endproperty
   a_tick: assert property (p_tick) else $error("ns step");
   property p_ns; s_fire ##0 $past(md) == 2'h1 |-> cv == $past(ns_time);
   endproperty
   a_ns: assert property (p_ns) else $error("ns latch");
   property p_clear; s_idle ##0 capture_done_clear[0] |=> !capture_done[0];
   endproperty
   a_clear: assert property (p_clear) else $error("done kept");
   property p_auto; capture_armed[0] && md == 2'h3 |=> capture_armed[0];
   endproperty
   a_auto: assert property (p_auto) else $error("no rearm");
endmodule // capture_checker
bind position_time_capture_unit capture_checker #(.VALUE_WIDTH(VALUE_WIDTH),
   .CHANNELS(CHANNELS)) i_capture_checker (.clock(clock), .arst_n(arst_n),
   .capture_content_select(capture_content_select), .ns_time(ns_time),
   .capture_arm(capture_arm), .capture_done_clear(capture_done_clear),
   .captured_value(captured_value), .capture_armed(capture_armed),
   .capture_done(capture_done));
`default_nettype wire

// ### testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock, arst_n;
   logic [10:0] pins;
   logic [15:0] rnd;
   logic [7:0] src, psrc;
   logic [3:0] cont, edg, pol, pedg;
   logic [1:0] arm, clr;
   logic [95:0] h0;
   logic [31:0] ns_ref;
   wire [6:0] digital_in;
   wire [2:0] serial_in;
   wire encoder_index;
   wire [31:0] motor_position, dc_time, ns_time;
   wire [63:0] captured_value;
   wire [1:0] capture_armed, capture_done;
   integer num_errors, tests_run, i, j;
   function [15:0] lfsr(input [15:0] v);
      lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   initial
   begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   field_model i_field_model (.clock(clock), .pin_req(pins), .noise(rnd),
      .digital_in(digital_in), .serial_in(serial_in),
      .encoder_index(encoder_index), .motor_position(motor_position),
      .dc_time(dc_time));
   position_time_capture_unit i_position_time_capture_unit (.clock(clock),
      .arst_n(arst_n), .digital_in(digital_in), .serial_in(serial_in),
      .encoder_index(encoder_index), .motor_position(motor_position),
      .dc_time(dc_time), .capture_source_select(src),
      .capture_content_select(cont), .capture_edge_select(edg),
      .precondition_policy(pol), .precondition_edge_select(pedg),
      .precondition_source_select(psrc), .capture_arm(arm),
      .capture_done_clear(clr), .captured_value(captured_value),
      .capture_armed(capture_armed), .capture_done(capture_done),
      .ns_time(ns_time));
   // reference nanosecond clock kept by the bench, not read from the unit
   always @(posedge clock or negedge arst_n)
   begin
      if (!arst_n)
         ns_ref <= 32'h0;
      else
         ns_ref <= ns_ref + 32'd40;
   end
   // reference: what each content source held at the latest edge
   always @(posedge clock)
   begin
      h0 <= {dc_time, ns_ref, motor_position};
   end
   always @(negedge clock) rnd <= lfsr(rnd);
   task finish_test;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, num_errors);
         if (num_errors == 0 && tests_run > 0)
            $display("== PASSED ==");
         else
            $display("== FAILED ==");
         $finish;
      end
   endtask
   task check(input ok, input [8*6-1:0] msg);
      begin
         tests_run = tests_run + 1;
         if (ok !== 1'b1)
         begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0t %0s", $time, msg);
         end
      end
   endtask
   // one-cycle arm or clear request
   task strobe(input integer ch, input is_arm);
      begin
         if (is_arm)
            arm[ch] = 1'b1;
         else
            clr[ch] = 1'b1;
         @(negedge clock);
         arm = 2'h0;
         clr = 2'h0;
         @(negedge clock);
      end
   endtask
   // 75 cycles is the whole latch budget; a miss ends the run
   task expect_fire(input integer ch, input exp);
      integer n, k;
      begin
         n = 0;
         while (capture_done[ch] !== 1'b1 && n < (exp ? 75 : 12))
         begin
            @(negedge clock);
            n = n + 1;
         end
         check((capture_done[ch] === 1'b1) === exp, "fire");
         k = cont[ch*2 +: 2] == 2'h3 ? 0 : cont[ch*2 +: 2];
         if (exp)
            check(captured_value[ch*32 +: 32] === h0[k*32 +: 32], "value");
         if (exp && capture_done[ch] !== 1'b1)
            finish_test;
      end
   endtask
   initial
   begin
      {num_errors, tests_run, pins, arm, clr, pol} = 0;
      {src, psrc, cont, edg, pedg} = {8'h00, 8'h10, 4'h8, 4'h5, 4'h5};
      {h0, rnd} = {96'h0, 16'hf3f1};
      arst_n = 1'b0;
      repeat (8) @(negedge clock);
      arst_n = 1'b1;
      @(negedge clock);
      check(captured_value === 64'h0 && capture_done === 2'h0, "reset");
      check(ns_time === ns_ref, "ns");
      // every source, content 0..2 and edge 1..3 on channel 0
      for (i = 0; i < 11; i = i + 1)
      begin
         {src[3:0], cont[1:0], edg[1:0]} = {i[3:0], i[1:0] % 2'h3, 2'h1};
         edg[1:0] = edg[1:0] + i % 3;
         pins[i] = (i % 3 == 1);
         strobe(0, 1'b0);
         pins[i] = ~pins[i];
         repeat (4) @(negedge clock);
         pins[i] = ~pins[i];
         expect_fire(0, 1'b0);
         strobe(0, 1'b1);
         pins[(i + 1) % 11] = ~pins[(i + 1) % 11];
         expect_fire(0, 1'b0);
         pins[i] = ~pins[i];
         expect_fire(0, 1'b1);
      end
      $display("source sweep over");
      pins = 11'h000;
      // channel 1: capture on input one, precondition on input two
      for (i = 1; i < 4; i = i + 1)
      begin
         pol[3:2] = i[1:0];
         pins[1] = (i == 3);
         repeat (4) @(negedge clock);
         strobe(1, 1'b1);
         for (j = 0; j < 2; j = j + 1)
         begin
            pins[0] = 1'b1;
            expect_fire(1, j[0]);
            pins[0] = 1'b0;
            pins[1] = (i != 3);
            repeat (4) @(negedge clock);
         end
      end
      $display("precondition over");
      // index mode on rising edges; source select is overridden by mode
      {src[3:0], cont[1:0], edg[1:0]} = 8'h0d;
      strobe(0, 1'b1);
      for (j = 0; j < 2; j = j + 1)
      begin
         strobe(0, 1'b0);
         pins[10] = 1'b1;
         expect_fire(0, 1'b1);
         pins[10] = 1'b0;
         repeat (4) @(negedge clock);
      end
      $display("index mode over");
      arst_n = 1'b0;
      @(negedge clock);
      check(capture_armed === 2'h0, "rst2");
      arst_n = 1'b1;
      repeat (2) @(negedge clock);
      check(capture_armed === 2'h0 && captured_value === 64'h0, "rst3");
      check(ns_time === ns_ref, "ns2");
      $display("reset over");
      finish_test;
   end
endmodule // testbench
`default_nettype wire
